// ### logic/sam_pkg.sv
// Shared constants and types for the slave address matcher.
// Assumes a 32-bit APB register bus and a 7/10-bit two-wire slave link.
package sam_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS = 8'h04;
    localparam logic [7:0] OWN_OFS  = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;

    // Control register field positions
    localparam int BIT_MODULE_ON  = 15;
    localparam int BIT_HALT_IDLE  = 13;
    localparam int BIT_CLK_REL    = 12;
    localparam int BIT_ACCEPT_ALL = 11;
    localparam int BIT_TEN_BIT    = 10;
    localparam int BIT_GC_EN      = 7;
    localparam int BIT_STRETCH_EN = 6;

    // Reset values and writable bits
    localparam logic [15:0] CTRL_RST   = 16'h1000;
    localparam logic [15:0] CTRL_WMASK = 16'hBFFF;
    localparam logic [9:0]  MASK_RST   = 10'h000;
    localparam logic [9:0]  OWN_RST    = 10'h000;

    // Status register field positions
    localparam int ST_ADDRESSED = 0;
    localparam int ST_GCALL     = 1;
    localparam int ST_RW        = 2;
    localparam int ST_TEN_DONE  = 3;
    localparam int ST_BYTE_LSB  = 8;

    // Address patterns in the upper four or five bits of a 7-bit address
    localparam logic [4:0] HI_RSV  = 5'h1F;
    localparam logic [4:0] TEN_HDR = 5'h1E;
    localparam logic [3:0] LOW_RSV = 4'h0;

    // Bits per address byte
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR1, ST_ACK1, ST_ADDR2, ST_ACK2, ST_SKIP
    } sam_state_t;
endpackage : sam_pkg

// ### logic/sam_cmp_if.sv
// Bundle between the link sequencer and the address comparator.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ns
interface sam_cmp_if (
    input wire logic clk,
    input wire logic reset_n
);
    logic [7:0] rx_byte;
    logic       second;
    logic       accept_all;
    logic       ten_bit;
    logic       gc_en;
    logic       addr10;
    logic [9:0] mask;
    logic [9:0] own;
    logic       ack;
    logic       gcall;
    logic       hdr_hit;

    modport seq (output rx_byte, second, accept_all, ten_bit, gc_en,
                 addr10, mask, own, input ack, gcall, hdr_hit);
    modport cmp (input clk, reset_n, rx_byte, second, accept_all,
                 ten_bit, gc_en, addr10, mask, own,
                 output ack, gcall, hdr_hit);
endinterface : sam_cmp_if

// ### logic/sam_addr_cmp.sv
// Combinational address comparator with masking and reserved filtering.
// Assumes the sequencer presents one full received byte at a time.
`timescale 1ns/1ns
module sam_addr_cmp (
    sam_cmp_if.cmp c
);
    import sam_pkg::*;

    logic [9:0] effm;
    logic [6:0] a7;
    logic       rw;
    logic [6:0] diff7;
    logic [1:0] hi2;
    logic [7:0] lo8;
    logic       is_gc;
    logic       rsv;
    logic       hdr_pat;

    always_comb begin
        effm    = c.accept_all ? 10'h000 : c.mask;
        a7      = c.rx_byte[7:1];
        rw      = c.rx_byte[0];
        diff7   = (a7 ^ c.own[6:0]) & ~effm[6:0];
        hi2     = (a7[1:0] ^ c.own[9:8]) & ~effm[9:8];
        lo8     = (c.rx_byte ^ c.own[7:0]) & ~effm[7:0];
        is_gc   = (a7 == 7'h00) && !rw;
        rsv     = (a7[6:3] == LOW_RSV) || (a7[6:2] == HI_RSV)
                  || (a7[6:2] == TEN_HDR);
        hdr_pat = a7[6:2] == TEN_HDR;
    end

    always_comb begin
        c.ack     = 1'b0;
        c.gcall   = 1'b0;
        c.hdr_hit = 1'b0;
        if (c.second) begin
            c.ack = c.accept_all || (lo8 == 8'h00);
        end else begin
            c.gcall   = is_gc && c.gc_en;
            // Header only counts as the upper byte of a 10-bit address
            c.hdr_hit = c.ten_bit && hdr_pat
                        && (c.accept_all || hi2 == 2'b00)
                        && (!rw || c.addr10 || c.accept_all);
            if (c.accept_all)
                c.ack = 1'b1;
            else if (c.ten_bit)
                c.ack = c.hdr_hit || c.gcall;
            else
                c.ack = c.gcall || (!rsv && diff7 == 7'h00);
        end
    end

    a_mask_dontcare: assert property (@(posedge c.clk)
        disable iff (!c.reset_n)
        !c.second && !c.ten_bit && !rsv
        && (((a7 ^ c.own[6:0]) & ~c.mask[6:0]) == 7'h00) |-> c.ack)
        else $error("masked 7-bit address not matched");
    a_mask_ten_low: assert property (@(posedge c.clk)
        disable iff (!c.reset_n)
        c.second && ((c.rx_byte ^ c.own[7:0]) & ~c.mask[7:0]) == 8'h00
        |-> c.ack)
        else $error("masked low 10-bit byte not matched");
    a_reserved_never: assert property (@(posedge c.clk)
        disable iff (!c.reset_n)
        !c.second && !c.accept_all && rsv && !hdr_pat && !is_gc
        |-> !c.ack)
        else $error("reserved address acknowledged");
    a_gcall_gate: assert property (@(posedge c.clk)
        disable iff (!c.reset_n)
        !c.second && !c.accept_all && is_gc |-> c.ack == c.gc_en)
        else $error("general call ack disagrees with enable");
    a_hdr_seven: assert property (@(posedge c.clk)
        disable iff (!c.reset_n)
        !c.second && !c.ten_bit && !c.accept_all && hdr_pat |-> !c.ack)
        else $error("10-bit header matched in 7-bit mode");
    a_accept_every: assert property (@(posedge c.clk)
        disable iff (!c.reset_n)
        c.accept_all |-> c.ack)
        else $error("accept-all mode refused an address");
    a_unmasked_diff: assert property (@(posedge c.clk)
        disable iff (!c.reset_n)
        !c.second && !c.ten_bit && !c.accept_all && !is_gc
        && diff7 != 7'h00 |-> !c.ack)
        else $error("address matched with differing bits");
endmodule : sam_addr_cmp

// ### logic/sam_top.sv
// Two-wire slave address recognition with an APB register file.
// Assumes scl/sda are raw pins, sampled on clk (250 MHz) after 2 flops.
`timescale 1ns/1ns
//
// Function
// - A set mask bit makes that address bit match either value.
// - Masking covers every compared bit in 7-bit and 10-bit modes.
// - Mask applies only while accept-all mode is off.
// - Reserved 7-bit addresses other than general call and the 10-bit header are matched only in accept-all mode, whatever the mask.
// - General call is acknowledged only when its enable is set or accept-all mode is on.
// - The 11110xx header matches only as a 10-bit upper byte or in accept-all mode.
// - Accept-all mode acknowledges every received address.
module sam_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Two-wire link pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Link state
    output logic             addressed
);
    import sam_pkg::*;

    sam_cmp_if cif (.clk(clk), .reset_n(reset_n));

    sam_addr_cmp u_cmp (.c(cif));

    logic [15:0] ctrl_r;
    logic [9:0]  mask_r;
    logic [9:0]  own_r;
    logic [1:0]  scl_s_r;
    logic [1:0]  sda_s_r;
    logic        scl_d_r;
    logic        sda_d_r;
    sam_state_t  state_r;
    logic [3:0]  cnt_r;
    logic [7:0]  shift_r;
    logic        oe_r;
    logic        addr10_r;
    logic        addressed_r;
    logic        gcall_r;
    logic        rw_r;
    logic [7:0]  last_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        wr_go;
    logic        mapped;
    logic        ack_now;
    logic        byte_end;

    assign pready    = pready_r;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;
    assign sda_oe    = oe_r;
    assign addressed = addressed_r;

    // Open-drain: only ever pulls low
    always_ff @(posedge clk) begin
        sda_o <= 1'b0;
    end

    // Pin synchronisers; idle bus reads high
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_s_r <= 2'b11;
            sda_s_r <= 2'b11;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    always_comb begin
        scl_rise = scl_s_r[1] && !scl_d_r;
        scl_fall = !scl_s_r[1] && scl_d_r;
        start_c  = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
        stop_c   = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
        // A stale count in the acknowledge or skip states must not claim
        byte_end = scl_fall && cnt_r == BYTE_BITS && ctrl_r[BIT_MODULE_ON]
                   && (state_r == ST_ADDR1 || state_r == ST_ADDR2);
        ack_now  = byte_end && cif.ack;
    end

    // Comparator inputs
    always_comb begin
        cif.rx_byte    = shift_r;
        cif.second     = state_r == ST_ADDR2;
        cif.accept_all = ctrl_r[BIT_ACCEPT_ALL];
        cif.ten_bit    = ctrl_r[BIT_TEN_BIT];
        cif.gc_en      = ctrl_r[BIT_GC_EN];
        cif.addr10     = addr10_r;
        cif.mask       = mask_r;
        cif.own        = own_r;
    end

    // Address phase sequencer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 4'h0;
            shift_r  <= 8'h00;
            oe_r     <= 1'b0;
            addr10_r <= 1'b0;
        end else if (!ctrl_r[BIT_MODULE_ON]) begin
            state_r  <= ST_IDLE;
            oe_r     <= 1'b0;
            addr10_r <= 1'b0;
        end else if (start_c) begin
            // A repeated start keeps the 10-bit match for a read header
            state_r <= ST_ADDR1;
            cnt_r   <= 4'h0;
            oe_r    <= 1'b0;
        end else if (stop_c) begin
            state_r  <= ST_IDLE;
            oe_r     <= 1'b0;
            addr10_r <= 1'b0;
        end else begin
            case (state_r)
                ST_ADDR1, ST_ADDR2: begin
                    if (scl_rise && cnt_r != BYTE_BITS) begin
                        shift_r <= {shift_r[6:0], sda_s_r[1]};
                        cnt_r   <= cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == BYTE_BITS) begin
                        if (cif.ack) begin
                            oe_r    <= 1'b1;
                            state_r <= (state_r == ST_ADDR1)
                                       ? ST_ACK1 : ST_ACK2;
                        end else begin
                            state_r <= ST_SKIP;
                        end
                    end
                end
                ST_ACK1: begin
                    if (scl_fall) begin
                        oe_r  <= 1'b0;
                        cnt_r <= 4'h0;
                        if (cif.hdr_hit && !shift_r[0] && !addr10_r)
                            state_r <= ST_ADDR2;
                        else
                            state_r <= ST_SKIP;
                    end
                end
                ST_ACK2: begin
                    if (scl_fall) begin
                        oe_r     <= 1'b0;
                        addr10_r <= 1'b1;
                        state_r  <= ST_SKIP;
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    oe_r <= 1'b0;
                end
                default: begin
                    state_r <= ST_IDLE;
                    oe_r    <= 1'b0;
                end
            endcase
        end
    end

    // Status; hardware set wins over a software clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            addressed_r <= 1'b0;
            gcall_r     <= 1'b0;
            rw_r        <= 1'b0;
            last_r      <= 8'h00;
        end else begin
            if (stop_c || !ctrl_r[BIT_MODULE_ON])
                addressed_r <= 1'b0;
            else if (ack_now)
                addressed_r <= 1'b1;
            if (ack_now && cif.gcall && !cif.second)
                gcall_r <= 1'b1;
            else if (wr_go && paddr == STAT_OFS && pwdata[ST_GCALL])
                gcall_r <= 1'b0;
            if (ack_now && !cif.second)
                rw_r <= shift_r[0];
            if (byte_end)
                last_r <= shift_r;
        end
    end

    // APB slave: one wait state, pready comes straight from a flop
    always_comb begin
        wr_go  = psel && penable && pready_r && pwrite;
        mapped = paddr == CTRL_OFS || paddr == MASK_OFS
                 || paddr == OWN_OFS || paddr == STAT_OFS;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RST;
            mask_r <= MASK_RST;
            own_r  <= OWN_RST;
        end else begin
            if (wr_go && paddr == CTRL_OFS)
                ctrl_r <= pwdata[15:0] & CTRL_WMASK;
            else if (ack_now && !cif.second && shift_r[0]
                     && ctrl_r[BIT_STRETCH_EN])
                // Hold the clock for software once a read is claimed
                ctrl_r[BIT_CLK_REL] <= 1'b0;
            if (wr_go && paddr == MASK_OFS)
                mask_r <= pwdata[9:0];
            if (wr_go && paddr == OWN_OFS)
                own_r <= pwdata[9:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !mapped;
            prdata_r  <= 32'h0000_0000;
            if (psel && penable && !pready_r && !pwrite) begin
                case (paddr)
                    CTRL_OFS: prdata_r <= {16'h0000, ctrl_r};
                    MASK_OFS: prdata_r <= {22'h000000, mask_r};
                    OWN_OFS:  prdata_r <= {22'h000000, own_r};
                    STAT_OFS: prdata_r <= {16'h0000, last_r, 4'h0,
                                           addr10_r, rw_r, gcall_r,
                                           addressed_r};
                    default:  prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    a_ack_drive: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_r[BIT_MODULE_ON] && !start_c && !stop_c && ack_now
        && (state_r == ST_ADDR1 || state_r == ST_ADDR2)
        |=> oe_r && addressed_r)
        else $error("acknowledge not driven after match");
    a_nack_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_r[BIT_MODULE_ON] && !start_c && !stop_c && state_r == ST_ADDR1
        && scl_fall && cnt_r == BYTE_BITS && !cif.ack
        |=> !oe_r && state_r == ST_SKIP)
        else $error("unmatched address was acknowledged");
    a_ack_release: assert property (@(posedge clk) disable iff (!reset_n)
        oe_r && scl_fall |=> !oe_r)
        else $error("acknowledge held past its clock");
    a_ten_second: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == ST_ADDR2 |-> ctrl_r[BIT_TEN_BIT])
        else $error("second address byte outside 10-bit mode");
    a_apb_ready: assert property (@(posedge clk) disable iff (!reset_n)
        psel && penable && !pready_r |=> pready_r ##1 !pready_r)
        else $error("APB ready not a single pulse");
    a_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        !ctrl_r[BIT_MODULE_ON] |=> !oe_r && !addressed_r)
        else $error("link claimed while module is off");
    a_accept_claim: assert property (@(posedge clk)
        disable iff (!reset_n)
        ctrl_r[BIT_ACCEPT_ALL] && byte_end && !start_c && !stop_c
        |=> oe_r && addressed_r)
        else $error("accept-all mode left an address unanswered");
    a_gcall_set: assert property (@(posedge clk)
        disable iff (!reset_n)
        ack_now && cif.gcall |=> gcall_r)
        else $error("general call not recorded");
    a_gcall_gated: assert property (@(posedge clk)
        disable iff (!reset_n)
        !ctrl_r[BIT_GC_EN] && !gcall_r |=> !gcall_r)
        else $error("general call recorded while disabled");
    a_unmapped_err: assert property (@(posedge clk) disable iff (!reset_n)
        psel && penable && !pready_r && !mapped
        |=> pready_r && pslverr_r && prdata_r == 32'h0000_0000)
        else $error("unmapped access not refused");

    c_seven_ack: cover property (@(posedge clk) disable iff (!reset_n)
        ack_now && !ctrl_r[BIT_TEN_BIT] && !cif.gcall);
    c_ten_ack: cover property (@(posedge clk) disable iff (!reset_n)
        ack_now && state_r == ST_ADDR2);
    c_gcall: cover property (@(posedge clk) disable iff (!reset_n)
        ack_now && cif.gcall);
    c_accept_all: cover property (@(posedge clk) disable iff (!reset_n)
        ack_now && ctrl_r[BIT_ACCEPT_ALL]);
endmodule : sam_top

// ### sim/sam_link_master.sv
// Behavioural two-wire bus master that drives the slave's link pins.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
module sam_link_master (
    // Clock
    input  wire logic clk,
    // Bus lines
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // Quarter of the 80 ns link period, in 4 ns clocks
    localparam int QTR = 5;

    // Both lines idle high, and the clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_q(input int n);
        repeat (n * QTR) @(posedge clk);
    endtask : wait_q

    task automatic start_cond();
        wait_q(1);
        sda_drv <= 1'b0;
        wait_q(2);
        scl <= 1'b0;
    endtask : start_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            wait_q(1);
            sda_drv <= b[i];
            wait_q(1);
            scl <= 1'b1;
            wait_q(2);
            scl <= 1'b0;
        end
        wait_q(1);
        sda_drv <= 1'b1;
        wait_q(1);
        scl <= 1'b1;
        wait_q(1);
        // Sampled mid-high, well after the slave's sync delay
        ack = ~sda_line;
        wait_q(1);
        scl <= 1'b0;
    endtask : send_byte

    task automatic stop_cond();
        wait_q(1);
        sda_drv <= 1'b0;
        wait_q(1);
        scl <= 1'b1;
        wait_q(1);
        sda_drv <= 1'b1;
        wait_q(2);
    endtask : stop_cond
endmodule : sam_link_master

// ### sim/tb_top.sv
// Self-checking bench for the slave address matcher.
// Assumes APB register access and a behavioural link master.
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    mismatches++; $display("Error at %0t: got %h expected %h", \
    $time, got, exp); end end
module tb_top;
    import sam_pkg::*;
    logic        clk, reset_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic        pready, pslverr, sda_o, sda_oe, addressed;
    logic        scl, sda_drv, rd_e;
    int          mismatches, checks_done;
    logic [15:0] rnd_r = 16'h005B;
    wire         sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);

    sam_top dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .addressed(addressed));
    sam_link_master u_master (.clk(clk), .sda_line(sda_line),
        .scl(scl), .sda_drv(sda_drv));

    function automatic logic [15:0] next_rnd();
        rnd_r = {rnd_r[14:0], rnd_r[15] ^ rnd_r[13] ^ rnd_r[12] ^ rnd_r[10]};
        return rnd_r;
    endfunction : next_rnd

    function automatic logic exp7(logic [15:0] c, logic [9:0] m,
                                  logic [9:0] o, logic [7:0] b);
        logic [6:0] a;
        a = b[7:1];
        if (!c[BIT_MODULE_ON]) return 1'b0;
        if (c[BIT_ACCEPT_ALL]) return 1'b1;
        if (a == 7'h00) return ~b[0] & c[BIT_GC_EN];
        if (a[6:3] == LOW_RSV || a[6:2] == HI_RSV || a[6:2] == TEN_HDR)
            return 1'b0;
        return ((a ^ o[6:0]) & ~m[6:0]) == 7'h00;
    endfunction : exp7

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready, data and error are taken at the edge that sees ready
        do @(posedge clk); while (pready !== 1'b1);
        rd_q = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cfg(logic [15:0] c, logic [9:0] m, logic [9:0] o);
        apb(1'b1, CTRL_OFS, {16'h0000, c});
        apb(1'b1, MASK_OFS, {22'h000000, m});
        apb(1'b1, OWN_OFS, {22'h000000, o});
        // Clear the sticky general-call flag so each frame stands alone
        apb(1'b1, STAT_OFS, 32'h00000002);
    endtask : cfg

    task automatic try7(logic [15:0] c, logic [9:0] m, logic [9:0] o,
                        logic [7:0] b);
        logic ack, e, g;
        e = exp7(c, m, o, b);
        g = c[BIT_MODULE_ON] & c[BIT_GC_EN] & (b == 8'h00);
        cfg(c, m, o);
        u_master.start_cond();
        u_master.send_byte(b, ack);
        `CHK(ack, e)
        `CHK(addressed, e)
        apb(1'b0, STAT_OFS, 32'h0);
        `CHK(rd_q[ST_GCALL], g)
        if (c[BIT_MODULE_ON]) `CHK(rd_q[ST_BYTE_LSB +: 8], b)
        if (e) `CHK(rd_q[ST_RW], b[0])
        u_master.stop_cond();
    endtask : try7

    task automatic try10(logic [15:0] c, logic [9:0] m, logic [9:0] o,
                         logic [1:0] hi, logic [7:0] lo);
        logic ack, hok, lok;
        hok = c[BIT_MODULE_ON] && (c[BIT_ACCEPT_ALL]
              || ((hi ^ o[9:8]) & ~m[9:8]) == 2'h0);
        lok = hok && (c[BIT_ACCEPT_ALL]
              || ((lo ^ o[7:0]) & ~m[7:0]) == 8'h00);
        cfg(c, m, o);
        u_master.start_cond();
        u_master.send_byte({TEN_HDR, hi, 1'b0}, ack);
        `CHK(ack, hok)
        u_master.send_byte(lo, ack);
        `CHK(ack, lok)
        // The header acknowledge already marks the device as addressed
        `CHK(addressed, hok)
        u_master.stop_cond();
    endtask : try10

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [15:0] r, c;
        logic [9:0]  o, m;
        logic [7:0]  b;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        reset_n = 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd_q, {16'h0000, CTRL_RST})
        `CHK(rd_e, 1'b0)
        apb(1'b0, MASK_OFS, 32'h0);
        `CHK(rd_q, 32'h00000000)
        apb(1'b1, CTRL_OFS, 32'hFFFFFFFF);
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd_q, {16'h0000, CTRL_WMASK})
        apb(1'b1, OWN_OFS, 32'hFFFFFFFF);
        apb(1'b0, OWN_OFS, 32'h0);
        `CHK(rd_q, 32'h000003FF)
        // Unmapped place answers with an error and no data
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd_e, 1'b1)
        `CHK(rd_q, 32'h00000000)
        // Reserved addresses with a fully open mask
        for (int k = 0; k < 16; k++) begin
            r = next_rnd();
            b = (k < 8) ? 8'(k) : 8'(8'h70 + k);
            try7(16'h9000 | {8'h00, r[0], 7'h00}, 10'h3FF, 10'h000,
                 {b[6:0], r[1]});
        end
        try7(16'h9800, 10'h000, 10'h055, 8'hF1);
        // Claiming a read with stretching on drops the clock release bit
        try7(16'h9040, 10'h000, 10'h012, 8'h25);
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd_q, 32'h00008040)
        for (int k = 0; k < 40; k++) begin
            r = next_rnd();
            o = 10'(next_rnd());
            m = 10'(next_rnd() & next_rnd());
            c = 16'h1000 | {(r[3:0] != 4'h0), 15'h0000}
                | {4'h0, (r[5:4] == 2'h0), 3'h0, r[6], 7'h00};
            case (r[9:8])
                2'h0: b = {o[6:0] ^ (7'(next_rnd()) & m[6:0]), r[10]};
                2'h1: b = {o[6:0], r[10]};
                default: b = 8'(next_rnd());
            endcase
            try7(c, m, o, b);
        end
        try10(16'h9400, 10'h3FF, 10'h2A5, 2'h1, 8'h5A);
        for (int k = 0; k < 20; k++) begin
            r = next_rnd();
            o = 10'(next_rnd());
            m = 10'(next_rnd() & next_rnd());
            try10(16'h9400 | {4'h0, r[5] & r[6], 3'h0, r[4], 7'h00}, m, o,
                  r[0] ? o[9:8] ^ (r[2:1] & m[9:8]) : r[2:1],
                  r[3] ? o[7:0] ^ (8'(next_rnd()) & m[7:0])
                       : 8'(next_rnd()));
        end
        give_verdict();
    end
endmodule : tb_top
